// ===== include/servo_kill_pkg.sv
// constants for the servo fault kill monitor
package servo_kill_pkg;
    // ==================================================
    // timing
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
    localparam int unsigned SERVO_CYCLE_US = 120;
    localparam int unsigned SERVO_CYCLE_CYC = (SERVO_CYCLE_US * 1000) / CLK_PERIOD_NS;
    localparam logic [10:0] DIV_LAST = 11'(SERVO_CYCLE_CYC - 1);
    localparam logic [11:0] LED_HALF_TICKS = 12'h800;
    // ==================================================
    // register byte offsets
    localparam logic [5:0] OFF_COND_EN = 6'h00;
    localparam logic [5:0] OFF_COND_STATE = 6'h04;
    localparam logic [5:0] OFF_KILL_CFG = 6'h08;
    localparam logic [5:0] OFF_PLR_CFG = 6'h0c;
    localparam logic [5:0] OFF_LV_THRESH = 6'h10;
    localparam logic [5:0] OFF_ERR_LIMIT = 6'h14;
    localparam logic [5:0] OFF_TEMP_TRIP = 6'h18;
    localparam logic [5:0] OFF_DELAY = 6'h1c;
    localparam logic [5:0] OFF_STATUS = 6'h20;
    localparam logic [5:0] OFF_COMMAND = 6'h24;
    // ==================================================
    // status word bit positions
    localparam int NCOND = 15;
    localparam int B_INDEX = 0;
    localparam int B_ZERO = 1;
    localparam int B_POS = 2;
    localparam int B_NEG = 3;
    localparam int B_IO1 = 4;
    localparam int B_IO3 = 6;
    localparam int B_OVTEMP = 7;
    localparam int B_MOVERR = 8;
    localparam int B_HOLDERR = 9;
    localparam int B_HALT = 10;
    localparam int B_STOPMOVE = 11;
    localparam int B_DELAY = 12;
    localparam int B_OVVOLT = 13;
    localparam int B_UNVOLT = 14;
    // ==================================================
    // config and command fields
    localparam int CFG_RUN = 0;
    localparam int CFG_KEEP_DRV = 1;
    localparam int CFG_MULTITASK = 2;
    localparam int CFG_EXT_ENC = 3;
    localparam int CFG_ADDR_LSB = 16;
    localparam int CMD_HALT = 0;
    localparam int CMD_ENABLE_DRV = 1;
    localparam int ST_KILLED = 16;
    localparam int ST_LV = 17;
    localparam int ST_DRV = 18;
    localparam int ST_LED = 19;
    // ==================================================
    // reset values
    localparam logic [14:0] COND_EN_RST = 15'h0080;
    localparam logic [14:0] COND_STATE_RST = 15'h7fff;
    localparam logic [31:0] KILL_CFG_RST = 32'h0000_0001;
    localparam logic [31:0] PLR_CFG_RST = 32'h0000_0001;
    localparam logic [15:0] LV_THRESH_RST = 16'h0000;
    localparam logic [31:0] ERR_LIMIT_RST = 32'hffff_ffff;
    localparam logic [15:0] TEMP_TRIP_RST = 16'hffff;
endpackage : servo_kill_pkg

// ===== rtl/servo_fault_kill_monitor.sv
// servo fault kill monitor with avalon-mm register slave
//
// Added by the designer: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps

// Functional notes
// - evaluate enabled conditions every 120 us cycle
// - matching condition loads kill recovery program immediately
// - over-voltage always kills regardless of enables
// - fifteen conditions, each enable and trigger polarity
// - conditions from status word; over-voltage forced enabled
// - low-voltage trip loads separate power-low program
// - trip below threshold; power-low disables driver
// - index from internal or configured external encoder
// - calculations set zero, positive, negative flags
// - digital inputs one to three are conditions
// - over-temperature ORs sensors, always enabled
// - large frame low enable line sets over-temp
// - moving and holding error against limits
// - halt disables driver, sets halt condition
// - input-terminated move sets stopped-move condition
// - delay counts down, zero sets exhausted
// - enabled over-voltage runs recovery, not bare shutdown
// - recovery does nothing or runs stored program
// - default recovery blinks green led after kill
// - writing one to enable bit enables condition
// - kill aborts motion and disables drivers by default
module servo_fault_kill_monitor (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // avalon-mm slave
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // condition sources
    input wire logic index_internal,
    input wire logic index_external,
    input wire logic calc_valid,
    input wire logic [31:0] calc_result,
    input wire logic [6:0] digital_in,
    input wire logic driver_thermal,
    input wire logic [15:0] electronics_temp,
    input wire logic large_frame,
    input wire logic driver_enable_line_low,
    input wire logic moving,
    input wire logic [31:0] position_error,
    input wire logic input_stopped_move,
    input wire logic over_voltage,
    input wire logic under_voltage,
    input wire logic [15:0] supply_voltage,
    // recovery actions
    output logic kill_abort,
    output logic kill_load,
    output logic [15:0] kill_program_addr,
    output logic plr_load,
    output logic [15:0] plr_program_addr,
    output logic driver_enable,
    output logic status_led
);
    // ==================================================
    // registers
    logic [14:0] cond_en_reg;
    logic [14:0] cond_state_reg;
    logic [31:0] kill_cfg_reg;
    logic [31:0] plr_cfg_reg;
    logic [15:0] lv_thresh_reg;
    logic [31:0] err_limit_reg;
    logic [15:0] temp_trip_reg;
    logic [31:0] delay_cnt_reg;
    logic ack_reg;
    logic tick;
    logic [10:0] div_reg;
    logic killed_reg;
    logic lv_reg;
    logic index_reg, zero_reg, pos_reg, neg_reg;
    logic moverr_reg, holderr_reg, halt_reg, stop_reg, delay_exh_reg;
    logic [11:0] led_cnt_reg;
    logic [14:0] internal_status_word;
    logic [14:0] en_eff;
    logic trig;
    logic over_temp;
    logic [31:0] abs_err;
    logic ov_bare;
    logic wr_go, rd_go, wr_en, wr_cmd, kill_now, lv_now;

    // ==================================================
    // bus slave: one wait cycle per access
    assign waitrequest = (read | write) & ~ack_reg;
    assign wr_go = write & ack_reg;
    assign rd_go = read & ~ack_reg;
    assign wr_en = wr_go && address == servo_kill_pkg::OFF_COND_EN;
    assign wr_cmd = wr_go && address == servo_kill_pkg::OFF_COMMAND;

    always_ff @(posedge mclk) begin
        if (srst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (read | write) & ~ack_reg;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            cond_en_reg <= servo_kill_pkg::COND_EN_RST;
            cond_state_reg <= servo_kill_pkg::COND_STATE_RST;
            kill_cfg_reg <= servo_kill_pkg::KILL_CFG_RST;
            plr_cfg_reg <= servo_kill_pkg::PLR_CFG_RST;
            lv_thresh_reg <= servo_kill_pkg::LV_THRESH_RST;
            err_limit_reg <= servo_kill_pkg::ERR_LIMIT_RST;
            temp_trip_reg <= servo_kill_pkg::TEMP_TRIP_RST;
        end else if (wr_go) begin
            case (address)
                servo_kill_pkg::OFF_COND_EN: cond_en_reg <= writedata[14:0];
                servo_kill_pkg::OFF_COND_STATE: cond_state_reg <= writedata[14:0];
                servo_kill_pkg::OFF_KILL_CFG: kill_cfg_reg <= writedata;
                servo_kill_pkg::OFF_PLR_CFG: plr_cfg_reg <= writedata;
                servo_kill_pkg::OFF_LV_THRESH: lv_thresh_reg <= writedata[15:0];
                servo_kill_pkg::OFF_ERR_LIMIT: err_limit_reg <= writedata;
                servo_kill_pkg::OFF_TEMP_TRIP: temp_trip_reg <= writedata[15:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            readdata <= 32'h0000_0000;
        end else if (rd_go) begin
            case (address)
                servo_kill_pkg::OFF_COND_EN: readdata <= {17'h00000, cond_en_reg};
                servo_kill_pkg::OFF_COND_STATE: readdata <= {17'h00000, cond_state_reg};
                servo_kill_pkg::OFF_KILL_CFG: readdata <= kill_cfg_reg;
                servo_kill_pkg::OFF_PLR_CFG: readdata <= plr_cfg_reg;
                servo_kill_pkg::OFF_LV_THRESH: readdata <= {16'h0000, lv_thresh_reg};
                servo_kill_pkg::OFF_ERR_LIMIT: readdata <= err_limit_reg;
                servo_kill_pkg::OFF_TEMP_TRIP: readdata <= {16'h0000, temp_trip_reg};
                servo_kill_pkg::OFF_DELAY: readdata <= delay_cnt_reg;
                servo_kill_pkg::OFF_STATUS: begin
                    readdata <= {12'h000, status_led, driver_enable, lv_reg, killed_reg,
                                 1'b0, internal_status_word};
                end
                default: readdata <= 32'h0000_0000;
            endcase
        end
    end

    // ==================================================
    // servo cycle divider
    assign tick = div_reg == servo_kill_pkg::DIV_LAST;

    always_ff @(posedge mclk) begin
        if (srst || tick) begin
            div_reg <= 11'h000;
        end else begin
            div_reg <= div_reg + 11'h001;
        end
    end

    // ==================================================
    // condition sources; set wins over the rewrite clear
    assign over_temp = driver_thermal | (electronics_temp > temp_trip_reg)
                     | (large_frame & driver_enable_line_low);
    assign abs_err = position_error[31] ? 32'(-position_error) : position_error;

    always_ff @(posedge mclk) begin
        if (srst) begin
            index_reg <= 1'b0;
        end else if (index_internal
                     || (index_external && kill_cfg_reg[servo_kill_pkg::CFG_EXT_ENC])) begin
            index_reg <= 1'b1;
        end else if (wr_en) begin
            index_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            zero_reg <= 1'b0;
            pos_reg <= 1'b0;
            neg_reg <= 1'b0;
        end else if (calc_valid) begin
            zero_reg <= calc_result == 32'h0000_0000;
            pos_reg <= !calc_result[31] && calc_result != 32'h0000_0000;
            neg_reg <= calc_result[31];
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            moverr_reg <= 1'b0;
            holderr_reg <= 1'b0;
        end else if (tick) begin
            moverr_reg <= moving && abs_err > {16'h0000, err_limit_reg[15:0]};
            holderr_reg <= !moving && abs_err > {16'h0000, err_limit_reg[31:16]};
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            halt_reg <= 1'b0;
        end else if (wr_cmd && writedata[servo_kill_pkg::CMD_HALT]) begin
            halt_reg <= 1'b1;
        end else if (wr_en) begin
            halt_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            stop_reg <= 1'b0;
        end else if (input_stopped_move) begin
            stop_reg <= 1'b1;
        end else if (wr_en) begin
            stop_reg <= 1'b0;
        end
    end

    // delay counts servo cycles; a watchdog needs the flag enabled
    always_ff @(posedge mclk) begin
        if (srst) begin
            delay_cnt_reg <= 32'h0000_0000;
            delay_exh_reg <= 1'b0;
        end else begin
            if (wr_go && address == servo_kill_pkg::OFF_DELAY) begin
                delay_cnt_reg <= writedata;
            end else if (tick && delay_cnt_reg != 32'h0000_0000) begin
                delay_cnt_reg <= delay_cnt_reg - 32'h0000_0001;
            end
            if (tick && delay_cnt_reg == 32'h0000_0001) begin
                delay_exh_reg <= 1'b1;
            end else if (wr_en) begin
                delay_exh_reg <= 1'b0;
            end
        end
    end

    // ==================================================
    // status word and trigger
    always_comb begin
        internal_status_word = 15'h0000;
        internal_status_word[servo_kill_pkg::B_INDEX] = index_reg;
        internal_status_word[servo_kill_pkg::B_ZERO] = zero_reg;
        internal_status_word[servo_kill_pkg::B_POS] = pos_reg;
        internal_status_word[servo_kill_pkg::B_NEG] = neg_reg;
        internal_status_word[servo_kill_pkg::B_IO3:servo_kill_pkg::B_IO1] = digital_in[2:0];
        internal_status_word[servo_kill_pkg::B_OVTEMP] = over_temp;
        internal_status_word[servo_kill_pkg::B_MOVERR] = moverr_reg;
        internal_status_word[servo_kill_pkg::B_HOLDERR] = holderr_reg;
        internal_status_word[servo_kill_pkg::B_HALT] = halt_reg;
        internal_status_word[servo_kill_pkg::B_STOPMOVE] = stop_reg;
        internal_status_word[servo_kill_pkg::B_DELAY] = delay_exh_reg;
        internal_status_word[servo_kill_pkg::B_OVVOLT] = over_voltage;
        internal_status_word[servo_kill_pkg::B_UNVOLT] = under_voltage;
    end

    // forced bits keep their cond_state_reg polarity; raw over_voltage and over_temp are also ORed into trig
    always_comb begin
        en_eff = cond_en_reg;
        en_eff[servo_kill_pkg::B_OVVOLT] = 1'b1;
        en_eff[servo_kill_pkg::B_OVTEMP] = 1'b1;
    end

    assign trig = |(en_eff & ~(internal_status_word ^ cond_state_reg)) || over_voltage || over_temp;
    assign ov_bare = over_voltage && !cond_en_reg[servo_kill_pkg::B_OVVOLT]
                   && !(|(en_eff & ~(internal_status_word ^ cond_state_reg) & ~15'h2000));
    assign kill_now = tick && trig && !killed_reg;
    assign lv_now = tick && supply_voltage < lv_thresh_reg && !lv_reg;

    // ==================================================
    // kill latch and recovery pulses
    always_ff @(posedge mclk) begin
        if (srst) begin
            killed_reg <= 1'b0;
        end else if (kill_now) begin
            killed_reg <= 1'b1;
        end else if (wr_en) begin
            killed_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            kill_abort <= 1'b0;
            kill_load <= 1'b0;
            kill_program_addr <= 16'h0000;
        end else begin
            kill_abort <= kill_now;
            kill_load <= kill_now && kill_cfg_reg[servo_kill_pkg::CFG_RUN]
                       && !ov_bare;
            if (kill_now) begin
                kill_program_addr <= kill_cfg_reg[31:servo_kill_pkg::CFG_ADDR_LSB];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            lv_reg <= 1'b0;
            plr_load <= 1'b0;
            plr_program_addr <= 16'h0000;
        end else begin
            plr_load <= lv_now && plr_cfg_reg[servo_kill_pkg::CFG_RUN];
            if (lv_now) begin
                lv_reg <= 1'b1;
                plr_program_addr <= plr_cfg_reg[31:servo_kill_pkg::CFG_ADDR_LSB];
            end else if (wr_go && address == servo_kill_pkg::OFF_LV_THRESH) begin
                lv_reg <= 1'b0;
            end
        end
    end

    // keeping the driver needs multitasking as well; a bare over-voltage always cuts it
    always_ff @(posedge mclk) begin
        if (srst) begin
            driver_enable <= 1'b1;
        end else if ((kill_now && !(kill_cfg_reg[servo_kill_pkg::CFG_KEEP_DRV]
                      && kill_cfg_reg[servo_kill_pkg::CFG_MULTITASK] && !ov_bare))
                     || lv_now
                     || (wr_cmd && writedata[servo_kill_pkg::CMD_HALT])) begin
            driver_enable <= 1'b0;
        end else if (wr_cmd && writedata[servo_kill_pkg::CMD_ENABLE_DRV]) begin
            driver_enable <= 1'b1;
        end
    end

    // led blinks while killed, paced by servo cycles
    always_ff @(posedge mclk) begin
        if (srst || !killed_reg) begin
            led_cnt_reg <= 12'h000;
            status_led <= 1'b0;
        end else if (tick) begin
            if (led_cnt_reg == servo_kill_pkg::LED_HALF_TICKS - 12'h001) begin
                led_cnt_reg <= 12'h000;
                status_led <= ~status_led;
            end else begin
                led_cnt_reg <= led_cnt_reg + 12'h001;
            end
        end
    end

    // ==================================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    logic [11:0] gap_reg;
    always_ff @(posedge mclk) begin
        if (srst || tick) begin
            gap_reg <= 12'h000;
        end else if (gap_reg != 12'hfff) begin
            gap_reg <= gap_reg + 12'h001;
        end
    end

    property p_tick_period;
        tick |-> gap_reg == 12'(servo_kill_pkg::SERVO_CYCLE_CYC - 1);
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("servo tick spacing wrong");

    property p_kill_match;
        tick && trig && !killed_reg |=> kill_abort && killed_reg;
    endproperty
    a_kill_match: assert property (p_kill_match) else $error("kill not raised");

    property p_ov_kill;
        tick && over_voltage && !killed_reg |=> kill_abort;
    endproperty
    a_ov_kill: assert property (p_ov_kill) else $error("over-voltage did not kill");

    property p_ov_bare;
        kill_now && ov_bare |=> !kill_load && !driver_enable;
    endproperty
    a_ov_bare: assert property (p_ov_bare) else $error("bare over-voltage ran program");

    sequence s_killed;
        kill_abort ##1 !kill_abort [*3];
    endsequence
    property p_once;
        kill_abort && !wr_en |-> s_killed;
    endproperty
    a_once: assert property (p_once) else $error("kill repeated");

    property p_lv;
        lv_now |=> !driver_enable && lv_reg && plr_load == plr_cfg_reg[0];
    endproperty
    a_lv: assert property (p_lv) else $error("low-voltage trip wrong");

    property p_halt;
        wr_cmd && writedata[0] |=> halt_reg && !driver_enable;
    endproperty
    a_halt: assert property (p_halt) else $error("halt not applied");

    property p_delay;
        tick && !wr_go && delay_cnt_reg == 32'h0000_0001 |=> delay_exh_reg && delay_cnt_reg == 32'h0;
    endproperty
    a_delay: assert property (p_delay) else $error("delay expiry missed");

    property p_calc;
        calc_valid && calc_result == 32'h0 |=> zero_reg && !pos_reg && !neg_reg;
    endproperty
    a_calc: assert property (p_calc) else $error("zero flag wrong");

    sequence s_access;
        waitrequest ##1 !waitrequest;
    endsequence
    property p_bus;
        (read || write) && !ack_reg |-> s_access;
    endproperty
    a_bus: assert property (p_bus) else $error("bus answer timing wrong");
endmodule : servo_fault_kill_monitor

// ===== tb/servo_plant_model.sv
// plant, sensor and input model driving the monitor's condition sources
`timescale 1ns/1ps
module servo_plant_model (
    // clock
    input wire logic mclk,
    // sensors and inputs
    output logic index_internal,
    output logic index_external,
    output logic calc_valid,
    output logic [31:0] calc_result,
    output logic [6:0] digital_in,
    output logic driver_thermal,
    output logic [15:0] electronics_temp,
    output logic large_frame,
    output logic driver_enable_line_low,
    output logic moving,
    output logic [31:0] position_error,
    output logic input_stopped_move,
    output logic over_voltage,
    output logic under_voltage,
    output logic [15:0] supply_voltage
);
    // ==========
    // quiet plant at start
    initial begin
        {index_internal, index_external, calc_valid, digital_in, driver_thermal} = '0;
        {large_frame, driver_enable_line_low, moving, input_stopped_move} = '0;
        over_voltage = 1'b0;
        under_voltage = 1'b0; // never raised, low supply goes the power-low way
        calc_result = 32'h0;
        position_error = 32'h0;
        electronics_temp = 16'h0050;
        supply_voltage = 16'h0200;
    end
    // ==========
    // event lines are one-cycle pulses
    always @(posedge mclk) begin
        if (index_internal) index_internal <= 1'b0;
        if (index_external) index_external <= 1'b0;
        if (calc_valid) calc_valid <= 1'b0;
        if (input_stopped_move) input_stopped_move <= 1'b0;
    end
    // ==========
    // raise or clear one source, called right after a rising edge
    task automatic set_src(input int src, input logic v);
        case (src)
            0: index_internal <= v;
            17: index_external <= v;
            3: begin
                calc_valid <= 1'b1;
                calc_result <= v ? 32'hffff_fffb : 32'h0000_0005;
            end
            4, 5, 6: digital_in[src - 4] <= v;
            7: driver_thermal <= v;
            15: electronics_temp <= v ? 16'h0200 : 16'h0050;
            16: {large_frame, driver_enable_line_low} <= {v, v};
            8: begin
                moving <= v;
                position_error <= v ? 32'h0000_0030 : 32'h0;
            end
            11: input_stopped_move <= v;
            13: over_voltage <= v;
            18: supply_voltage <= v ? 16'h0080 : 16'h0200;
            default: ;
        endcase
    endtask : set_src
endmodule : servo_plant_model

// ===== tb/test_servo_fault_kill_monitor.sv
// self-checking bench for the servo fault kill monitor
`timescale 1ns/1ps
module test_servo_fault_kill_monitor;
    // ==========
    // signals
    localparam int TICK = 120_000 / 100;
    logic mclk, srst, read, write, waitrequest;
    logic [5:0] address;
    logic [31:0] writedata, readdata, calc_result, position_error, q;
    logic index_internal, index_external, calc_valid, driver_thermal, large_frame;
    logic driver_enable_line_low, moving, input_stopped_move, over_voltage, under_voltage;
    logic [6:0] digital_in;
    logic [15:0] electronics_temp, supply_voltage, kill_program_addr, plr_program_addr, ad;
    logic kill_abort, kill_load, plr_load, driver_enable, status_led, ka, kl, pl, de;
    int err_count, cmp_count, cyc, ref_cyc;
    // ==========
    // design and plant
    servo_fault_kill_monitor i_servo_fault_kill_monitor (
        .mclk, .srst, .address, .read, .write, .writedata, .readdata, .waitrequest,
        .index_internal, .index_external, .calc_valid, .calc_result, .digital_in,
        .driver_thermal, .electronics_temp, .large_frame, .driver_enable_line_low,
        .moving, .position_error, .input_stopped_move, .over_voltage, .under_voltage,
        .supply_voltage, .kill_abort, .kill_load, .kill_program_addr, .plr_load,
        .plr_program_addr, .driver_enable, .status_led
    );
    servo_plant_model i_servo_plant_model (
        .mclk, .index_internal, .index_external, .calc_valid, .calc_result, .digital_in,
        .driver_thermal, .electronics_temp, .large_frame, .driver_enable_line_low,
        .moving, .position_error, .input_stopped_move, .over_voltage, .under_voltage,
        .supply_voltage
    );
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk) cyc <= srst ? 0 : cyc + 1;
    // ==========
    // shared tasks
    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask : chk
    // request held until waitrequest is seen low at a falling edge
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        @(negedge mclk);
        while (waitrequest !== 1'b0) begin
            n++;
            if (n > 20) begin
                err_count++;
                stop_test();
            end
            @(negedge mclk);
        end
        @(posedge mclk);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge mclk);
    endtask : bus
    // waits for a recovery pulse; every pulse must sit on the servo tick grid
    task automatic watch(input int lim);
        ka = 1'b0;
        pl = 1'b0;
        repeat (lim) begin
            @(negedge mclk);
            if (kill_abort === 1'b1 || plr_load === 1'b1) begin
                {ka, kl, pl, de, ad} = {kill_abort, kill_load, plr_load, driver_enable,
                    kill_program_addr};
                if (ref_cyc < 0) ref_cyc = cyc;
                else chk("tick phase", 0, (cyc - ref_cyc) % TICK);
                break;
            end
        end
        @(posedge mclk);
    endtask : watch
    task automatic rearm();
        bus(1'b1, servo_kill_pkg::OFF_COND_EN, 32'h80);
        bus(1'b1, servo_kill_pkg::OFF_COMMAND, 32'h2);
    endtask : rearm
    // ==========
    // scenarios
    task automatic try_cond(input int bit_no, input int src, input logic exp);
        bus(1'b1, servo_kill_pkg::OFF_COND_EN, 32'h80 | (32'h1 << bit_no));
        i_servo_plant_model.set_src(src, 1'b1);
        watch(2 * TICK + 100);
        chk("kill", 32'(exp), 32'(ka));
        if (exp) chk("drive after kill", 0, 32'(de));
        i_servo_plant_model.set_src(src, 1'b0);
        @(posedge mclk);
        rearm();
    endtask : try_cond
    task automatic s_ovolt(input logic [31:0] cfg, input logic run);
        bus(1'b1, servo_kill_pkg::OFF_KILL_CFG, cfg);
        bus(1'b1, servo_kill_pkg::OFF_COND_EN, run ? 32'h2080 : 32'h80);
        i_servo_plant_model.set_src(13, 1'b1);
        watch(2 * TICK);
        chk("ov kill", 1, 32'(ka));
        chk("ov load", 32'(run), 32'(kl));
        chk("ov drive", 32'(run), 32'(de));
        if (run) chk("ov addr", 32'(cfg[31:16]), 32'(ad));
        i_servo_plant_model.set_src(13, 1'b0);
        bus(1'b1, servo_kill_pkg::OFF_KILL_CFG, 32'h1);
        rearm();
    endtask : s_ovolt
    task automatic s_misc();
        bus(1'b1, servo_kill_pkg::OFF_COND_EN, 32'h90);
        i_servo_plant_model.set_src(4, 1'b1);
        watch(2 * TICK);
        watch(2 * TICK);
        chk("second kill", 0, 32'(ka));
        i_servo_plant_model.set_src(4, 1'b0);
        rearm();
        bus(1'b1, servo_kill_pkg::OFF_PLR_CFG, 32'h0123_0001);
        bus(1'b1, servo_kill_pkg::OFF_LV_THRESH, 32'h100);
        i_servo_plant_model.set_src(18, 1'b1);
        watch(2 * TICK);
        chk("power low load", 1, 32'(pl));
        chk("power low kill", 0, 32'(ka));
        chk("power low drive", 0, 32'(de));
        chk("power low addr", 32'h123, 32'(plr_program_addr));
        i_servo_plant_model.set_src(18, 1'b0);
        bus(1'b1, servo_kill_pkg::OFF_LV_THRESH, 32'h100);
        rearm();
        bus(1'b1, servo_kill_pkg::OFF_COND_EN, 32'h480);
        bus(1'b1, servo_kill_pkg::OFF_COMMAND, 32'h1);
        watch(2 * TICK);
        chk("halt kill", 1, 32'(ka));
        bus(1'b0, servo_kill_pkg::OFF_STATUS, 0);
        chk("halt status", 32'h1_0400, q & 32'hd_0400);
        rearm();
        bus(1'b1, servo_kill_pkg::OFF_COND_EN, 32'h1080);
        bus(1'b1, servo_kill_pkg::OFF_DELAY, 32'h3);
        watch(4 * TICK + 100);
        chk("delay kill", 1, 32'(ka));
        rearm();
    endtask : s_misc
    // ==========
    // main sequence
    initial begin
        {err_count, cmp_count, cyc, ref_cyc} = {32'sd0, 32'sd0, 32'sd0, -32'sd1};
        {srst, read, write, address, writedata} = {3'b100, 6'h00, 32'h0};
        repeat (16) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        bus(1'b0, servo_kill_pkg::OFF_COND_EN, 0);
        chk("cond_en reset", 32'h80, q);
        bus(1'b0, servo_kill_pkg::OFF_COND_STATE, 0);
        chk("cond_state reset", 32'h7fff, q);
        bus(1'b0, servo_kill_pkg::OFF_KILL_CFG, 0);
        chk("kill_cfg reset", 32'h1, q);
        bus(1'b0, 6'h28, 0);
        chk("unmapped", 0, q);
        bus(1'b1, servo_kill_pkg::OFF_COND_EN, 32'h2090);
        bus(1'b0, servo_kill_pkg::OFF_COND_EN, 0);
        chk("cond_en back", 32'h2090, q);
        rearm();
        bus(1'b1, servo_kill_pkg::OFF_TEMP_TRIP, 32'h100);
        bus(1'b1, servo_kill_pkg::OFF_ERR_LIMIT, 32'h0040_0020);
        try_cond(0, 0, 1'b1);
        try_cond(3, 3, 1'b1);
        for (int i = 4; i < 7; i++) try_cond(i, i, 1'b1);
        try_cond(7, 7, 1'b1);
        try_cond(7, 15, 1'b1);
        try_cond(7, 16, 1'b1);
        try_cond(8, 8, 1'b1);
        try_cond(11, 11, 1'b1);
        try_cond(0, 17, 1'b0);
        bus(1'b1, servo_kill_pkg::OFF_KILL_CFG, 32'h9);
        try_cond(0, 17, 1'b1);
        bus(1'b1, servo_kill_pkg::OFF_KILL_CFG, 32'h1);
        bus(1'b1, servo_kill_pkg::OFF_COND_STATE, 32'h7fef);
        try_cond(4, 4, 1'b0);
        try_cond(4, 99, 1'b1);
        bus(1'b1, servo_kill_pkg::OFF_COND_STATE, 32'h7fff);
        s_ovolt(32'h0000_0001, 1'b0);
        s_ovolt(32'h0abc_0007, 1'b1);
        s_misc();
        stop_test();
    end
    initial begin
        repeat (90_000) @(posedge mclk);
        err_count++;
        stop_test();
    end
endmodule : test_servo_fault_kill_monitor
